// *** common/svm_map.svh ***
// Constants for the supply voltage monitor: address, levels, timing
`ifndef SVM_MAP_SVH
`define SVM_MAP_SVH
`define SVM_CLK_HZ 250000000
`define SVM_MEAS_RATE_HZ 40
`define SVM_MEAS_PERIOD_CYC (`SVM_CLK_HZ / `SVM_MEAS_RATE_HZ)
`define SVM_SUPPLY_ADDR 8'hF9
`define SVM_RAM_AW 8
`define SVM_RAM_DW 24
`define SVM_CODE_W 8
// Code = (V - 2.0 V) * 64 / 1.6 V, so 2.2 V is code 8 and 0.1 V is 4 codes
`define SVM_LOW_BASE_CODE 8'h08
`define SVM_LOW_STEP_CODE 8'h04
`define SVM_EPR_LIMIT_CODE 8'h10
`define SVM_CORR_ONE 23'h200000
`define SVM_CORR_SHIFT 21
`define SVM_DIV_STEPS 6'h2D
`define SVM_REF_TRIM_REC 4'hA
`endif

// *** common/svm_pkg.sv ***
// Types shared by the supply voltage monitor design files
package svm_pkg;
  typedef enum logic [0:0] {
    SVM_WAIT_TICK,
    SVM_CONVERT
  } svm_meas_e;
  typedef struct packed {
    logic supply_low;
    logic epr_inhibit;
  } svm_status_s;
  typedef struct packed {
    logic valid;
    logic [23:0] data;
  } svm_result_s;
endpackage

// *** design/svm_ram.sv ***
// Word RAM holding the supply code cell and software words
`timescale 1ns/10ps
`include "svm_map.svh"
module svm_ram (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic hw_we_i,
  input wire logic [`SVM_RAM_AW-1:0] hw_addr_i,
  input wire logic [`SVM_RAM_DW-1:0] hw_data_i,
  input wire logic sw_we_i,
  input wire logic [`SVM_RAM_AW-1:0] sw_addr_i,
  input wire logic [`SVM_RAM_DW-1:0] sw_wdata_i,
  output logic [`SVM_RAM_DW-1:0] sw_rdata_o
);
  logic [`SVM_RAM_DW-1:0] mem [0:(1<<`SVM_RAM_AW)-1];
  logic [`SVM_RAM_DW-1:0] rdata_next;

  always_comb begin
    rdata_next = mem[sw_addr_i];
  end

  // Hardware write wins when both ports write the same word in one cycle
  always_ff @(posedge clk_i) begin
    if (hw_we_i) begin
      mem[hw_addr_i] <= hw_data_i;
    end
    if (sw_we_i && !(hw_we_i && hw_addr_i == sw_addr_i)) begin
      mem[sw_addr_i] <= sw_wdata_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sw_rdata_o <= '0;
    end else begin
      sw_rdata_o <= rdata_next;
    end
  end
endmodule

// *** design/svm_monitor.sv ***
// Supply voltage monitor: periodic measurement, low flag, EEPROM guard, gain fix
//
// Functional notes
// - The supply is measured against the bandgap reference forty times a second.
// - Each measured code is written into RAM word 249 for software to read.
// - The code means 2.0 V plus 1.6 V times code over 64.
// - A three-bit threshold select picks 2.2 V to 2.9 V in 0.1 V steps.
// - The supply-low flag is set while the supply is below the selected level.
// - Gain correction acts only with its enable at 1, using a signed 8-bit coefficient.
// - Corrected result is bridge result over one plus code times coefficient over 2^21.
// - Automatic EEPROM writes are suppressed while the supply is below 2.4 V.
`timescale 1ns/10ps
`include "svm_map.svh"
module svm_monitor
  import svm_pkg::*;
#(
  parameter int unsigned MEAS_PERIOD_CYC = `SVM_MEAS_PERIOD_CYC
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Bandgap conversion path
  output logic conv_req_o,
  input wire logic conv_done_i,
  input wire logic [`SVM_CODE_W-1:0] conv_code_i,
  // Configuration bits
  input wire logic [2:0] low_thresh_sel_i,
  input wire logic supply_gain_corr_en_i,
  input wire logic signed [7:0] supply_gain_coeff_i,
  // Strain result datapath
  input wire logic bridge_valid_i,
  input wire logic signed [23:0] bridge_result_i,
  output logic bridge_ready_o,
  output svm_result_s corr_result_o,
  // Automatic EEPROM write requests
  input wire logic epr_auto_req_i,
  output logic epr_auto_req_o,
  // Status and software view
  output logic [`SVM_CODE_W-1:0] supply_code_o,
  output svm_status_s status_o,
  input wire logic sw_we_i,
  input wire logic [`SVM_RAM_AW-1:0] sw_addr_i,
  input wire logic [`SVM_RAM_DW-1:0] sw_wdata_i,
  output logic [`SVM_RAM_DW-1:0] sw_rdata_o
);
  // Supply code for a 0.1 V level step above 2.2 V
  function automatic logic [7:0] low_level_code(input logic [2:0] sel);
    low_level_code = `SVM_LOW_BASE_CODE + 8'(`SVM_LOW_STEP_CODE * sel);
  endfunction

  // ---------------- Measurement sequencer ----------------
  svm_meas_e meas_reg, meas_next;
  logic [31:0] tick_cnt_reg, tick_cnt_next;
  logic [`SVM_CODE_W-1:0] code_reg, code_next;
  svm_status_s status_reg, status_next;
  logic store_reg, store_next;
  logic conv_req_reg, conv_req_next;

  always_comb begin
    meas_next = meas_reg;
    tick_cnt_next = tick_cnt_reg;
    code_next = code_reg;
    status_next = status_reg;
    store_next = 1'b0;
    conv_req_next = 1'b0;
    // Period counter keeps running during a conversion so the rate stays exact
    if (tick_cnt_reg == 32'(MEAS_PERIOD_CYC - 1)) begin
      tick_cnt_next = '0;
    end else begin
      tick_cnt_next = tick_cnt_reg + 32'h1;
    end
    unique case (meas_reg)
      SVM_WAIT_TICK: begin
        if (tick_cnt_reg == 32'(MEAS_PERIOD_CYC - 1)) begin
          conv_req_next = 1'b1;
          meas_next = SVM_CONVERT;
        end
      end
      SVM_CONVERT: begin
        if (conv_done_i) begin
          code_next = conv_code_i;
          store_next = 1'b1;
          status_next.supply_low = conv_code_i < low_level_code(low_thresh_sel_i);
          status_next.epr_inhibit = conv_code_i < `SVM_EPR_LIMIT_CODE;
          meas_next = SVM_WAIT_TICK;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      meas_reg <= SVM_WAIT_TICK;
      tick_cnt_reg <= '0;
      code_reg <= '0;
      status_reg <= '0;
      store_reg <= 1'b0;
      conv_req_reg <= 1'b0;
    end else begin
      meas_reg <= meas_next;
      tick_cnt_reg <= tick_cnt_next;
      code_reg <= code_next;
      status_reg <= status_next;
      store_reg <= store_next;
      conv_req_reg <= conv_req_next;
    end
  end

  assign conv_req_o = conv_req_reg;
  assign supply_code_o = code_reg;
  assign status_o = status_reg;
  assign epr_auto_req_o = epr_auto_req_i && !status_reg.epr_inhibit;

  svm_ram u_ram (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .hw_we_i(store_reg),
    .hw_addr_i(`SVM_SUPPLY_ADDR),
    .hw_data_i({{(`SVM_RAM_DW-`SVM_CODE_W){1'b0}}, code_reg}),
    .sw_we_i(sw_we_i),
    .sw_addr_i(sw_addr_i),
    .sw_wdata_i(sw_wdata_i),
    .sw_rdata_o(sw_rdata_o)
  );

  // ---------------- Gain correction divider ----------------
  // Restoring divide, one quotient bit per cycle; cheaper than a wide array.
  // Quotient is cut to 24 bits, so results past full scale wrap.
  logic busy_reg, busy_next;
  logic [5:0] step_reg, step_next;
  logic [22:0] rem_reg, rem_next;
  logic [44:0] quo_reg, quo_next;
  logic [22:0] den_reg, den_next;
  logic neg_reg, neg_next;
  svm_result_s res_reg, res_next;
  logic signed [16:0] corr_prod;
  logic [23:0] bridge_mag;
  logic [22:0] rem_shift;
  logic [23:0] quo_low;

  always_comb begin
    corr_prod = $signed({1'b0, code_reg}) * supply_gain_coeff_i;
    bridge_mag = bridge_result_i[23] ? 24'(-bridge_result_i) : bridge_result_i;
    rem_shift = {rem_reg[21:0], quo_reg[44]};
    quo_low = quo_reg[23:0];
    busy_next = busy_reg;
    step_next = step_reg;
    rem_next = rem_reg;
    quo_next = quo_reg;
    den_next = den_reg;
    neg_next = neg_reg;
    res_next = res_reg;
    res_next.valid = 1'b0;
    if (!busy_reg) begin
      if (bridge_valid_i) begin
        if (supply_gain_corr_en_i) begin
          busy_next = 1'b1;
          step_next = '0;
          rem_next = '0;
          quo_next = {bridge_mag, {`SVM_CORR_SHIFT{1'b0}}};
          den_next = `SVM_CORR_ONE + 23'(corr_prod);
          neg_next = bridge_result_i[23];
        end else begin
          res_next.valid = 1'b1;
          res_next.data = bridge_result_i;
        end
      end
    end else if (step_reg == `SVM_DIV_STEPS) begin
      busy_next = 1'b0;
      res_next.valid = 1'b1;
      res_next.data = neg_reg ? 24'(-quo_low) : quo_low;
    end else begin
      step_next = step_reg + 6'h1;
      if (rem_shift >= den_reg) begin
        rem_next = rem_shift - den_reg;
        quo_next = {quo_reg[43:0], 1'b1};
      end else begin
        rem_next = rem_shift;
        quo_next = {quo_reg[43:0], 1'b0};
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      busy_reg <= 1'b0;
      step_reg <= '0;
      rem_reg <= '0;
      quo_reg <= '0;
      den_reg <= '0;
      neg_reg <= 1'b0;
      res_reg <= '0;
    end else begin
      busy_reg <= busy_next;
      step_reg <= step_next;
      rem_reg <= rem_next;
      quo_reg <= quo_next;
      den_reg <= den_next;
      neg_reg <= neg_next;
      res_reg <= res_next;
    end
  end

  assign bridge_ready_o = !busy_reg;
  assign corr_result_o = res_reg;
endmodule

// *** dv/svm_conv_model.sv ***
// Behavioural bandgap converter answering conversion requests
`timescale 1ns/10ps
`include "svm_map.svh"
module svm_conv_model (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic conv_req_i,
  input wire logic [7:0] code_i,
  input wire logic [4:0] dly_i,
  output logic conv_done_o,
  output logic [7:0] conv_code_o
);
  localparam logic [3:0] REFERENCE_TRIM = 4'hA;
  logic [5:0] cnt;
  // Code line toggles outside a result so a stale value never matches
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt <= 6'h00;
      conv_done_o <= 1'b0;
      conv_code_o <= 8'hA5;
    end else begin
      conv_done_o <= cnt == 6'h01;
      // Trim away from its recommended value skews every code
      conv_code_o <= (cnt == 6'h01) ? code_i + 8'(REFERENCE_TRIM) - 8'(`SVM_REF_TRIM_REC)
        : ~conv_code_o;
      cnt <= conv_req_i ? {1'b0, dly_i} + 6'h01 : cnt - {5'h00, cnt != 6'h00};
    end
  end
endmodule

// *** dv/svm_monitor_properties.sv ***
// Port-level checks for the supply voltage monitor
`timescale 1ns/10ps
module svm_monitor_properties
  import svm_pkg::*;
#(
  parameter int unsigned MEAS_PERIOD_CYC = 20
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic conv_req_o,
  input wire logic conv_done_i,
  input wire logic [7:0] conv_code_i,
  input wire logic [2:0] low_thresh_sel_i,
  input wire logic supply_gain_corr_en_i,
  input wire logic bridge_valid_i,
  input wire logic signed [23:0] bridge_result_i,
  input wire logic bridge_ready_o,
  input wire svm_result_s corr_result_o,
  input wire logic epr_auto_req_i,
  input wire logic epr_auto_req_o,
  input wire logic [7:0] supply_code_o,
  input wire svm_status_s status_o
);
  logic pend_reg, pend_next, seen_reg, seen_next, store;
  logic [31:0] gap_reg, gap_next;
  assign store = conv_done_i && pend_reg;
  always_comb begin
    pend_next = (pend_reg && !conv_done_i) || conv_req_o;
    seen_next = seen_reg || conv_req_o;
    gap_next = conv_req_o ? 32'h0 : gap_reg + 32'h1;
  end
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pend_reg <= 1'b0;
      seen_reg <= 1'b0;
      gap_reg <= 32'h0;
    end else begin
      pend_reg <= pend_next;
      seen_reg <= seen_next;
      gap_reg <= gap_next;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  AST_PERIOD: assert property (conv_req_o |-> !pend_reg &&
    (!seen_reg || (gap_reg + 32'h1) % MEAS_PERIOD_CYC == 0)) else $error("bad request spacing");
  AST_STORE: assert property (store |=> supply_code_o == $past(conv_code_i))
    else $error("stored code wrong");
  AST_LOW: assert property (store |=> status_o.supply_low ==
    ($past(conv_code_i) < 8'h08 + {3'h0, $past(low_thresh_sel_i), 2'h0}))
    else $error("low flag");
  AST_INHIBIT: assert property (store |=>
    status_o.epr_inhibit == ($past(conv_code_i) < 8'h10)) else $error("inhibit wrong");
  AST_EPR_GATE: assert property (epr_auto_req_o == (epr_auto_req_i && !status_o.epr_inhibit))
    else $error("eeprom gate wrong");
  AST_HOLD: assert property (!store |=> $stable(status_o) && $stable(supply_code_o))
    else $error("status moved without store");
  AST_BYPASS: assert property (bridge_valid_i && bridge_ready_o && !supply_gain_corr_en_i |=>
    corr_result_o.valid && corr_result_o.data == $past(bridge_result_i)) else $error("bypass");
  AST_CORR_LAT: assert property (bridge_valid_i && bridge_ready_o &&
    supply_gain_corr_en_i |-> ##1 !bridge_ready_o ##46 (corr_result_o.valid && bridge_ready_o))
    else $error("corr latency");
endmodule
bind svm_monitor svm_monitor_properties #(.MEAS_PERIOD_CYC(MEAS_PERIOD_CYC)) u_prop (
  .clk_i(clk_i),
  .rst_b_i(rst_b_i),
  .conv_req_o(conv_req_o),
  .conv_done_i(conv_done_i),
  .conv_code_i(conv_code_i),
  .low_thresh_sel_i(low_thresh_sel_i),
  .supply_gain_corr_en_i(supply_gain_corr_en_i),
  .bridge_valid_i(bridge_valid_i),
  .bridge_result_i(bridge_result_i),
  .bridge_ready_o(bridge_ready_o),
  .corr_result_o(corr_result_o),
  .epr_auto_req_i(epr_auto_req_i),
  .epr_auto_req_o(epr_auto_req_o),
  .supply_code_o(supply_code_o),
  .status_o(status_o)
);

// *** dv/tb.sv ***
// Self-checking bench for the supply voltage monitor
`timescale 1ns/10ps
module tb;
  import svm_pkg::*;
  logic clk_i = 1'b0, rst_b_i = 1'b0, req, done, bv = 1'b0, en = 1'b0, epr = 1'b0, ready, epr_o;
  logic [7:0] code, scode, mcode = 8'h00, last = 8'h00, k = 8'h00;
  logic [2:0] sel = 3'h0, d = 3'h0;
  logic [4:0] dly = 5'h00;
  logic inh = 1'b0;
  logic [23:0] b = 24'h000000, rdata;
  logic [23:0] bq[$], rq[$];
  logic [9:0] mq[$], e;
  svm_result_s cr;
  svm_status_s st;
  int fail_count = 0, n_tests = 0, i;
  always #2 clk_i = ~clk_i;
  svm_monitor #(.MEAS_PERIOD_CYC(20)) u_dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .conv_req_o(req),
    .conv_done_i(done), .conv_code_i(code), .low_thresh_sel_i(sel), .supply_gain_corr_en_i(en),
    .supply_gain_coeff_i(k), .bridge_valid_i(bv), .bridge_result_i(b), .bridge_ready_o(ready),
    .corr_result_o(cr), .epr_auto_req_i(epr), .epr_auto_req_o(epr_o), .supply_code_o(scode),
    .status_o(st), .sw_we_i(1'b0), .sw_addr_i(8'hF9), .sw_wdata_i(24'h000000), .sw_rdata_o(rdata));
  svm_conv_model u_model (.clk_i(clk_i), .rst_b_i(rst_b_i), .conv_req_i(req), .code_i(mcode),
    .dly_i(dly), .conv_done_o(done), .conv_code_o(code));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  function automatic logic [23:0] corr(input logic [23:0] v, input logic [7:0] c,
    input logic [7:0] f);
    longint m, q;
    m = longint'(signed'(v));
    if (m < 0) m = -m;
    q = (m <<< 21) / (longint'(2097152) + longint'(c) * longint'(signed'(f)));
    return v[23] ? -q[23:0] : q[23:0];
  endfunction
  // Expectation noted per request; inputs only change between store and next request
  always @(posedge clk_i) begin
    epr <= 1'($urandom);
    d <= {d[1:0], done};
    if (req === 1'b1) begin
      mq.push_back({mcode, mcode < 8'h08 + {3'h0, sel, 2'h0}, mcode < 8'h10});
      rq.push_back({16'h0000, mcode});
    end
  end
  always @(negedge clk_i) begin
    if (d[0]) begin
      e = mq.pop_front();
      check({scode, st}, e);
      inh = e[0];
    end
    check(epr_o, epr & ~inh);
    if (d[2]) check(rdata, rq.pop_front());
    if (cr.valid === 1'b1) check(cr.data, bq.pop_front());
  end
  task automatic meas(input logic [7:0] c, input logic [2:0] s);
    int n;
    n = 0;
    @(posedge clk_i);
    mcode <= c;
    sel <= s;
    dly <= 5'($urandom % 16);
    last = c;
    do @(negedge clk_i); while (d[0] !== 1'b1 && ++n < 100);
    check(d[0], 1'b1);
  endtask
  task automatic bridge(input logic [23:0] v, input logic e, input logic [7:0] c);
    int n;
    n = 0;
    do @(negedge clk_i); while (ready !== 1'b1 && ++n < 100);
    check(ready, 1'b1);
    @(posedge clk_i);
    bv <= 1'b1;
    b <= v;
    en <= e;
    k <= c;
    bq.push_back(e ? corr(v, last, c) : v);
  endtask
  task rel;
    @(posedge clk_i);
    bv <= 1'b0;
  endtask
  initial begin
    #40000;
    fail_count++;
    give_verdict;
  end
  initial begin
    void'($urandom(90));
    repeat (4) @(posedge clk_i);
    rst_b_i <= 1'b1;
    for (i = 0; i < 8; i++) begin
      meas(8'h07 + {3'h0, i[2:0], 2'h0}, i[2:0]);
      meas(8'h08 + {3'h0, i[2:0], 2'h0}, i[2:0]);
      meas(8'($urandom), i[2:0]);
    end
    $display("test measure done");
    // Back to back in bypass, coefficient ignored
    for (i = 0; i < 4; i++) bridge(24'($urandom_range(1048575)) - 24'h080000, 1'b0, 8'($urandom));
    rel;
    for (i = 0; i < 3; i++) begin
      bridge(24'($urandom_range(1048575)) - 24'h080000, 1'b1,
        i == 0 ? 8'h80 : (i == 1 ? 8'h7F : 8'($urandom)));
      rel;
    end
    repeat (50) @(posedge clk_i);
    check(bq.size(), 0);
    check(mq.size() > 1, 0);
    $display("test bridge done");
    give_verdict;
  end
endmodule
